//--- hdl/udma_pkg.sv
// shared constants and carrier types for the burst handshake block
package udma_pkg;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  // words the host may still send after a pause request
  localparam int PAUSE_SLACK = 3;
  // pause once this many or fewer fifo slots remain free
  localparam logic [3:0] PAUSE_FREE = 4'h4;
  localparam logic [10:0] IDE_ADDR_MASK = 11'h007;
  localparam logic [10:0] CARD_ADDR_MASK = 11'h7FF;

  typedef enum logic {MODE_CARD, MODE_IDE} if_mode_t;

  typedef struct packed {
    logic req;
    logic ack;
    logic stop;
    logic strobe;
  } burst_pins_t;

  typedef struct packed {
    logic [10:0] addr;
    logic sel0_n;
    logic sel1_n;
  } addr_pins_t;
endpackage

//--- hdl/udma_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module udma_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [AW:0] count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = count_r != (AW+1)'(DEPTH);
  assign out_valid = count_r != '0;
  assign out_data = mem[rd_ptr_r];
  assign count = count_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // udma_fifo

//--- hdl/udma_burst_rx.sv
// device side of a data-out burst: strobe capture, pause and stop
// Operation
// - burst roles only once request and acknowledge
// - roles end when request, acknowledge negate
// - store up to three words after pause
// - request/acknowledge polarity follows interface mode
// - card mode eleven address bits, ide three
// - capture data only on host strobe edges
// - data-in: device sends at most three after pause; this block has no data-in path
`timescale 1ns/1ps
module udma_burst_rx
  import udma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ide_mode,
  input wire logic burst_enable,
  input wire logic dmack_pin,
  input wire logic stop_pin,
  input wire logic hstrobe_pin,
  input wire logic [DATA_W-1:0] hd_pin,
  input wire logic [10:0] ha_pin,
  input wire logic sel0_n_pin,
  input wire logic sel1_n_pin,
  output logic dmarq_pin,
  output logic ddmardy_n_pin,
  output logic [DATA_W-1:0] word_data,
  output logic word_valid,
  input wire logic word_ready,
  output logic burst_active,
  output logic overflow,
  output logic [10:0] port_addr,
  output logic port_sel0_n,
  output logic port_sel1_n
);
  burst_pins_t meta_r;
  burst_pins_t sync_r;
  logic [DATA_W-1:0] hd_meta_r;
  logic [DATA_W-1:0] hd_sync_r;
  addr_pins_t addr_meta_r;
  addr_pins_t addr_sync_r;
  logic strobe_last_r;
  logic active_r;
  logic ack_on;
  logic strobe_edge;
  logic fifo_in_ready;
  logic [FIFO_AW:0] fifo_count;
  logic [DATA_W-1:0] fifo_out_data;
  logic fifo_out_valid;
  logic pause_r;
  logic ddmardy_n_r;
  logic [1:0] slack_r;
  logic req_r;
  logic req_mode_r;
  logic overflow_r;
  logic [DATA_W-1:0] word_data_r;
  logic word_valid_r;
  logic [10:0] port_addr_r;
  logic sel0_r;
  logic sel1_r;
  logic fifo_pop;

  function automatic logic pol(input logic level, input logic ide);
    return ide ? ~level : level;
  endfunction

  // two-stage synchronisers for everything arriving from pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      hd_meta_r <= '0;
      hd_sync_r <= '0;
      addr_meta_r <= '{addr: 11'h000, sel0_n: 1'b1, sel1_n: 1'b1};
      addr_sync_r <= '{addr: 11'h000, sel0_n: 1'b1, sel1_n: 1'b1};
    end else begin
      meta_r <= '{req: 1'b0, ack: dmack_pin, stop: stop_pin,
                  strobe: hstrobe_pin};
      sync_r <= meta_r;
      hd_meta_r <= hd_pin;
      hd_sync_r <= hd_meta_r;
      addr_meta_r <= '{addr: ha_pin, sel0_n: sel0_n_pin,
                       sel1_n: sel1_n_pin};
      addr_sync_r <= addr_meta_r;
    end
  end

  // ide mode takes request/acknowledge as active low
  assign ack_on = pol(sync_r.ack, ide_mode);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_last_r <= 1'b0;
    end else begin
      strobe_last_r <= sync_r.strobe;
    end
  end

  // both strobe edges count, only inside an active burst
  assign strobe_edge = active_r && (sync_r.strobe != strobe_last_r);

  // burst live only while both request and acknowledge assert
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= 1'b0;
    end else begin
      active_r <= req_r && ack_on;
    end
  end

  // request held while enabled, dropped on host stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= 1'b0;
    end else if (!burst_enable) begin
      req_r <= 1'b0;
    end else if (active_r && sync_r.stop) begin
      req_r <= 1'b0;
    end else if (!ack_on) begin
      req_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_mode_r <= 1'b0;
    end else begin
      req_mode_r <= ide_mode ? ~req_r : req_r;
    end
  end

  // pause keeps PAUSE_FREE slots for words still in flight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pause_r <= 1'b0;
    end else begin
      pause_r <= (4'(FIFO_DEPTH) - 4'(fifo_count)) <= PAUSE_FREE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slack_r <= 2'h0;
    end else if (!active_r || !ddmardy_n_r) begin
      // slack counts from the pause the host can see
      slack_r <= 2'(PAUSE_SLACK);
    end else if (strobe_edge && slack_r != 2'h0) begin
      slack_r <= slack_r - 2'h1;
    end
  end

  // ready pin registered, idle or paused shows not ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ddmardy_n_r <= 1'b1;
    end else begin
      ddmardy_n_r <= !(active_r && !pause_r);
    end
  end

  // a word beyond the slack or into a full fifo is flagged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_r <= 1'b0;
    end else if (!active_r && !req_r) begin
      overflow_r <= 1'b0;
    end else if (strobe_edge && (!fifo_in_ready ||
                 (ddmardy_n_r && slack_r == 2'h0))) begin
      overflow_r <= 1'b1;
    end
  end

  udma_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(hd_sync_r),
    .in_valid(strobe_edge),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .count(fifo_count)
  );

  // registered output stage
  assign fifo_pop = fifo_out_valid && (!word_valid_r || word_ready);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_valid_r <= 1'b0;
      word_data_r <= '0;
    end else if (fifo_pop) begin
      word_valid_r <= 1'b1;
      word_data_r <= fifo_out_data;
    end else if (word_ready) begin
      word_valid_r <= 1'b0;
    end
  end

  // address width follows mode, selects pass through registered in both modes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_addr_r <= 11'h000;
      sel0_r <= 1'b1;
      sel1_r <= 1'b1;
    end else begin
      port_addr_r <= addr_sync_r.addr &
                     (ide_mode ? IDE_ADDR_MASK : CARD_ADDR_MASK);
      sel0_r <= addr_sync_r.sel0_n;
      sel1_r <= addr_sync_r.sel1_n;
    end
  end

  assign dmarq_pin = req_mode_r;
  assign ddmardy_n_pin = ddmardy_n_r;
  assign word_data = word_data_r;
  assign word_valid = word_valid_r;
  assign burst_active = active_r;
  assign overflow = overflow_r;
  assign port_addr = port_addr_r;
  assign port_sel0_n = sel0_r;
  assign port_sel1_n = sel1_r;

  property p_no_capture_idle;
    @(posedge clk) disable iff (!rst_n)
      !active_r |-> !strobe_edge;
  endproperty
  a_no_capture_idle: assert property (p_no_capture_idle)
    else $error("word captured outside burst");

  property p_end_on_ack;
    @(posedge clk) disable iff (!rst_n)
      !ack_on |=> !active_r;
  endproperty
  a_end_on_ack: assert property (p_end_on_ack)
    else $error("burst stayed active after negation");

  property p_slack_ok;
    @(posedge clk) disable iff (!rst_n)
      $rose(pause_r) ##0 active_r ##0 fifo_in_ready [*4] |-> !overflow_r;
  endproperty
  a_slack_ok: assert property (p_slack_ok)
    else $error("slack word lost");

  property p_ide_addr;
    @(posedge clk) disable iff (!rst_n)
      ide_mode && $stable(ide_mode) |=> port_addr_r[10:3] == 8'h00;
  endproperty
  a_ide_addr: assert property (p_ide_addr)
    else $error("upper address bits in ide mode");

  property p_edge_push;
    @(posedge clk) disable iff (!rst_n)
      strobe_edge && fifo_in_ready && !fifo_pop |=>
        fifo_count == $past(fifo_count) + 4'h1;
  endproperty
  a_edge_push: assert property (p_edge_push)
    else $error("strobe edge did not store one word");

  property p_req_pol;
    @(posedge clk) disable iff (!rst_n)
      $stable(ide_mode) ##1 $stable(ide_mode) |->
        dmarq_pin == (ide_mode ? ~$past(req_r) : $past(req_r));
  endproperty
  a_req_pol: assert property (p_req_pol)
    else $error("request polarity wrong for mode");

  property p_ready_idle;
    @(posedge clk) disable iff (!rst_n)
      !active_r |=> ddmardy_n_pin;
  endproperty
  a_ready_idle: assert property (p_ready_idle)
    else $error("ready shown outside burst");

  property p_pause_ready;
    @(posedge clk) disable iff (!rst_n)
      pause_r |=> ddmardy_n_pin;
  endproperty
  a_pause_ready: assert property (p_pause_ready)
    else $error("ready shown while paused");
endmodule // udma_burst_rx

//--- verification/udma_host.sv
// host model for data-out bursts: acknowledge, strobe, data and stop
`timescale 1ns/1ps
module udma_host #(
  parameter int RP_WAIT_NS = 100
) (
  input wire logic ide_mode,
  input wire logic dmarq_pin,
  input wire logic ddmardy_n_pin,
  output logic dmack_pin,
  output logic stop_pin,
  output logic hstrobe_pin,
  output logic [15:0] hd_pin
);
  logic ack_r = 1'b0;
  initial begin
    stop_pin = 1'b0;
    hstrobe_pin = 1'b0;
    hd_pin = 16'h0000;
  end
  // polarity follows the interface mode
  assign dmack_pin = ack_r ^ ide_mode;
  task automatic start();
    int n;
    n = 0;
    while (!(dmarq_pin ^ ide_mode) && n < 200) begin
      #25 n++;
    end
    ack_r = 1'b1;
  endtask
  // greedy ignores the pause request
  task automatic send(input int cnt, input logic [15:0] base,
                      input bit greedy, output int sent);
    int after;
    after = 0;
    sent = 0;
    for (int i = 0; i < cnt; i++) begin
      if (ddmardy_n_pin) after++;
      if (after > 3 && !greedy) break;
      hd_pin = base + 16'(i);
      #50 hstrobe_pin = ~hstrobe_pin;
      // hold over, data no longer valid
      #100 hd_pin = ~hd_pin;
      #50 sent++;
    end
  endtask
  task automatic finish_burst();
    int n;
    n = 0;
    // stop only a ready-to-pause interval after the last word
    #RP_WAIT_NS;
    stop_pin = 1'b1;
    while ((dmarq_pin ^ ide_mode) && n < 200) begin
      #25 n++;
    end
    ack_r = 1'b0;
    #100 stop_pin = 1'b0;
  endtask
endmodule // udma_host

//--- verification/testbench.sv
// self-checking bench for the data-out burst receiver
`timescale 1ns/1ps
module testbench;
  import udma_pkg::*;
  logic clk, rst_n, ide_mode, burst_enable, word_ready, sel0_n, sel1_n;
  logic dmack, stop, hstrobe, dmarq, ddmardy_n, word_valid;
  logic burst_active, overflow, psel0_n, psel1_n;
  logic [10:0] ha, port_addr;
  logic [DATA_W-1:0] hd, word_data;
  logic [15:0] got[$];
  int miscompares = 0;
  int cmp_count = 0;
  // output stage, fifo up to the pause mark, then the slack
  localparam int PAUSE_WORDS = 1 + FIFO_DEPTH - int'(PAUSE_FREE) + PAUSE_SLACK;
  int cyc = 0;
  udma_burst_rx dut (.clk(clk), .rst_n(rst_n), .ide_mode(ide_mode),
    .burst_enable(burst_enable), .dmack_pin(dmack), .stop_pin(stop),
    .hstrobe_pin(hstrobe), .hd_pin(hd), .ha_pin(ha), .sel0_n_pin(sel0_n),
    .sel1_n_pin(sel1_n), .dmarq_pin(dmarq), .ddmardy_n_pin(ddmardy_n),
    .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .burst_active(burst_active),
    .overflow(overflow), .port_addr(port_addr), .port_sel0_n(psel0_n),
    .port_sel1_n(psel1_n));
  udma_host host (.ide_mode(ide_mode), .dmarq_pin(dmarq),
    .ddmardy_n_pin(ddmardy_n), .dmack_pin(dmack), .stop_pin(stop),
    .hstrobe_pin(hstrobe), .hd_pin(hd));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) got.push_back(word_data);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] a, input logic [15:0] e);
    cmp_count++;
    if (a !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic check_words(input int n, input logic [15:0] base);
    check(16'(got.size()), 16'(n));
    for (int i = 0; i < n && i < got.size(); i++) begin
      check(got[i], base + 16'(i));
    end
  endtask
  // strobes without acknowledge must not yield words
  task automatic t_outside();
    int s;
    got.delete();
    host.send(4, 16'h1111, 1'b1, s);
    tick(8);
    check(16'(got.size()), 16'h0000);
    check(burst_active, 1'b0);
    check(ddmardy_n, 1'b1);
  endtask
  task automatic t_burst(input logic mode, input logic [15:0] base);
    int s;
    ide_mode = mode;
    got.delete();
    tick(6);
    check(port_addr, mode ? 16'h0007 : 16'h07FF);
    check(psel0_n, 1'b0);
    check(psel1_n, 1'b1);
    check(dmarq, 16'(!mode));
    host.start();
    tick(4);
    check(burst_active, 1'b1);
    host.send(5, base, 1'b0, s);
    tick(8);
    check_words(5, base);
    host.finish_burst();
    tick(4);
    check(burst_active, 1'b0);
  endtask
  task automatic t_pause(input bit greedy);
    int s;
    got.delete();
    word_ready = 1'b0;
    host.start();
    tick(4);
    host.send(greedy ? 9 : 10, 16'h2000, greedy, s);
    tick(8);
    check(overflow, 16'(greedy));
    if (!greedy) check(16'(s), 16'(PAUSE_WORDS));
    check(ddmardy_n, 1'b1);
    word_ready = 1'b1;
    tick(30);
    if (!greedy) check_words(PAUSE_WORDS, 16'h2000);
    host.finish_burst();
    tick(6);
    check(overflow, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ide_mode = 1'b0;
    burst_enable = 1'b1;
    word_ready = 1'b1;
    ha = 11'h7FF;
    sel0_n = 1'b0;
    sel1_n = 1'b1;
    tick(5);
    rst_n = 1'b1;
    tick(4);
    t_outside();
    t_burst(1'b0, 16'hA500);
    t_outside();
    t_burst(1'b1, 16'h5A00);
    t_pause(1'b0);
    t_pause(1'b1);
    tally_and_finish();
  end
endmodule // testbench
